// ### hw/aab_core.sv
// execution core for add/and and bit-oriented file instructions
// assumes one instruction offered per instr_valid cycle, pins asynchronous
//
// Operation
// - add literal to accumulator, sum to accumulator, update carry, digit carry, zero
// - add accumulator and file register, update carry, digit carry and zero
// - destination 0 sends result to accumulator, 1 back to file register
// - and literal into accumulator, result to accumulator, only zero flag changes
// - and accumulator with file, result to chosen destination, only zero changes
// - bit clear file forces chosen bit to zero, no flags change, other bits rewritten as read (pins at the port)
// - bit set file forces chosen bit to one, no flags change, other bits rewritten as read (pins at the port)
// - bit test reading one lets the following instruction run
// - bit test reading zero replaces following instruction with a no-operation
// - reading the port register uses pin levels, not the output latch
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module aab_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire aab_pkg::aab_op_t instr_op,
    input wire logic [7:0] instr_lit,
    input wire logic [6:0] instr_file,
    input wire logic instr_dest,
    input wire logic [2:0] instr_bit,
    output logic instr_retired,
    output logic instr_squashed,
    output logic skip_pending,
    output logic [7:0] acc,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    input wire logic [7:0] port_pins_in,
    output logic [7:0] port_latch,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] file_mem [0:aab_pkg::AAB_FILE_DEPTH-1];
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    aab_pkg::aab_state_t state;
    aab_pkg::aab_state_t next_state;
    logic exec;
    logic squash;
    logic [7:0] operand;
    logic file_we;
    logic acc_we;
    logic add_op;
    logic and_op;
    logic bus_file_hit;
    logic bus_acc_hit;
    logic bus_status_hit;
    logic bus_port_hit;
    logic bus_mem_hit;
    logic mem_we;
    logic latch_we;
    logic test_op;
    logic skip_cond;
    logic [7:0] next_rdata;

    aab_alu_if alu_bus ();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // file read: the port address reflects pins rather than the latch
    function automatic logic [7:0] aab_file_read(
        input logic [6:0] addr,
        input logic [7:0] pins,
        input logic [7:0] mem_val
    );
        aab_file_read = (addr == aab_pkg::AAB_PORT_FILE_ADDR) ? pins : mem_val;
    endfunction

    function automatic logic aab_is_file_dest(input aab_pkg::aab_op_t op, input logic d);
        case (op)
            aab_pkg::AAB_ADD_ACCUMULATOR_AND_FILE,
            aab_pkg::AAB_AND_ACCUMULATOR_WITH_FILE: begin
                aab_is_file_dest = (d == aab_pkg::DEST_FILE);
            end
            aab_pkg::AAB_BIT_CLEAR_FILE,
            aab_pkg::AAB_BIT_SET_FILE: begin
                aab_is_file_dest = 1'b1;
            end
            default: begin
                aab_is_file_dest = 1'b0;
            end
        endcase
    endfunction

    // status byte as seen on the register port; spare bits read zero
    function automatic logic [7:0] aab_status_pack(
        input logic c,
        input logic half,
        input logic z
    );
        logic [7:0] s;
        s = 8'h00;
        s[aab_pkg::AAB_STATUS_CARRY_POS] = c;
        s[aab_pkg::AAB_STATUS_DIGIT_CARRY_POS] = half;
        s[aab_pkg::AAB_STATUS_ZERO_POS] = z;
        aab_status_pack = s;
    endfunction

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    // two stages; only the second stage feeds any logic
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= port_pins_in;
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------
    // issue and skip control
    // ------------------------------------------------------------
    assign exec = instr_valid && (state == aab_pkg::AAB_ST_RUN);
    assign squash = instr_valid && (state == aab_pkg::AAB_ST_SKIP);
    // only an executed test arms a skip; a dropped one never does
    assign skip_cond = exec && test_op && !alu_bus.bit_val;

    always_comb begin
        next_state = state;
        case (state)
            aab_pkg::AAB_ST_RUN: begin
                if (skip_cond) begin
                    next_state = aab_pkg::AAB_ST_SKIP;
                end
            end
            aab_pkg::AAB_ST_SKIP: begin
                // held until the following instruction arrives and is dropped
                if (squash) begin
                    next_state = aab_pkg::AAB_ST_RUN;
                end
            end
            default: begin
                next_state = aab_pkg::AAB_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= aab_pkg::AAB_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // bit test reading one leaves state in run, next instruction executes
    assign skip_pending = (state == aab_pkg::AAB_ST_SKIP);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            instr_retired <= 1'b0;
            instr_squashed <= 1'b0;
        end else begin
            instr_retired <= exec;
            instr_squashed <= squash;
        end
    end

    // ------------------------------------------------------------
    // operand fetch and alu
    // ------------------------------------------------------------
    assign operand = aab_file_read(instr_file, pin_sync, file_mem[instr_file]);

    assign alu_bus.op = instr_op;
    assign alu_bus.acc = acc;
    assign alu_bus.operand = operand;
    assign alu_bus.lit = instr_lit;
    assign alu_bus.bit_sel = instr_bit;

    aab_alu u_alu (
        .alu(alu_bus)
    );

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    assign add_op = (instr_op == aab_pkg::AAB_ADD_LITERAL_TO_ACCUMULATOR)
        || (instr_op == aab_pkg::AAB_ADD_ACCUMULATOR_AND_FILE);
    assign and_op = (instr_op == aab_pkg::AAB_AND_LITERAL_INTO_ACCUMULATOR)
        || (instr_op == aab_pkg::AAB_AND_ACCUMULATOR_WITH_FILE);
    assign test_op = (instr_op == aab_pkg::AAB_TEST_BIT_SKIP_IF_ZERO);

    assign file_we = exec && aab_is_file_dest(instr_op, instr_dest);
    assign acc_we = exec && (add_op || and_op) && !file_we;
    assign mem_we = file_we && (instr_file != aab_pkg::AAB_PORT_FILE_ADDR);
    assign latch_we = file_we && (instr_file == aab_pkg::AAB_PORT_FILE_ADDR);

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    // the port address inside file space goes to the output latch, all else to the array
    assign bus_file_hit = bus_wr && (bus_addr <= aab_pkg::AAB_FILE_LAST);
    assign bus_port_hit = bus_file_hit && (bus_addr[6:0] == aab_pkg::AAB_PORT_FILE_ADDR);
    assign bus_mem_hit = bus_file_hit && (bus_addr[6:0] != aab_pkg::AAB_PORT_FILE_ADDR);
    assign bus_acc_hit = bus_wr && (bus_addr == aab_pkg::AAB_ACC_ADDR);
    assign bus_status_hit = bus_wr && (bus_addr == aab_pkg::AAB_STATUS_ADDR);

    // ------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------
    // an executing instruction wins over a bus write in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            acc <= aab_pkg::AAB_ACC_RESET;
        end else if (acc_we) begin
            acc <= alu_bus.result;
        end else if (bus_acc_hit) begin
            acc <= bus_wdata;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // instruction updates win over a bus write to the status register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            carry_flag <= aab_pkg::AAB_FLAG_RESET;
            digit_carry_flag <= aab_pkg::AAB_FLAG_RESET;
            zero_flag <= aab_pkg::AAB_FLAG_RESET;
        end else if (exec && add_op) begin
            carry_flag <= alu_bus.carry;
            digit_carry_flag <= alu_bus.digit_carry;
            zero_flag <= alu_bus.zero;
        end else if (exec && and_op) begin
            zero_flag <= alu_bus.zero;
        end else if (bus_status_hit) begin
            carry_flag <= bus_wdata[aab_pkg::AAB_STATUS_CARRY_POS];
            digit_carry_flag <= bus_wdata[aab_pkg::AAB_STATUS_DIGIT_CARRY_POS];
            zero_flag <= bus_wdata[aab_pkg::AAB_STATUS_ZERO_POS];
        end
    end

    // ------------------------------------------------------------
    // file registers
    // ------------------------------------------------------------
    // array left unreset: contents are undefined until written
    // single write port: a bus write beside an instruction write is lost
    always_ff @(posedge clk) begin
        if (mem_we) begin
            file_mem[instr_file] <= alu_bus.result;
        end else if (bus_mem_hit) begin
            file_mem[bus_addr[6:0]] <= bus_wdata;
        end
    end

    // writes to the port address land in the output latch
    always_ff @(posedge clk) begin
        if (!nrst) begin
            port_latch <= aab_pkg::AAB_PORT_LATCH_RESET;
        end else if (latch_we) begin
            port_latch <= alu_bus.result;
        end else if (bus_port_hit) begin
            port_latch <= bus_wdata;
        end
    end

    // ------------------------------------------------------------
    // register port read
    // ------------------------------------------------------------
    // data stand for exactly one cycle after the read strobe, zero otherwise,
    // so a stale value is never taken for a second read
    always_comb begin
        next_rdata = 8'h00;
        if (bus_rd) begin
            if (bus_addr <= aab_pkg::AAB_FILE_LAST) begin
                next_rdata = aab_file_read(bus_addr[6:0], pin_sync, file_mem[bus_addr[6:0]]);
            end else if (bus_addr == aab_pkg::AAB_ACC_ADDR) begin
                next_rdata = acc;
            end else if (bus_addr == aab_pkg::AAB_STATUS_ADDR) begin
                next_rdata = aab_status_pack(carry_flag, digit_carry_flag, zero_flag);
            end else if (bus_addr == aab_pkg::AAB_EXEC_ADDR) begin
                next_rdata = {7'h00, skip_pending};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus_rdata <= aab_pkg::AAB_RDATA_RESET;
        end else begin
            bus_rdata <= next_rdata;
        end
    end

endmodule

// ### hw/aab_pkg.sv
// package of constants and types for the accumulator alu and bit-op block
// assumes a single 40 mhz core clock and a synchronous active-low reset
package aab_pkg;

    // ------------------------------------------------------------
    // instruction set handled here
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        AAB_NOP,
        AAB_ADD_LITERAL_TO_ACCUMULATOR,
        AAB_ADD_ACCUMULATOR_AND_FILE,
        AAB_AND_LITERAL_INTO_ACCUMULATOR,
        AAB_AND_ACCUMULATOR_WITH_FILE,
        AAB_BIT_CLEAR_FILE,
        AAB_BIT_SET_FILE,
        AAB_TEST_BIT_SKIP_IF_ZERO
    } aab_op_t;

    // ------------------------------------------------------------
    // execution states
    // ------------------------------------------------------------
    typedef enum logic {
        AAB_ST_RUN,
        AAB_ST_SKIP
    } aab_state_t;

    // ------------------------------------------------------------
    // widths and file space
    // ------------------------------------------------------------
    localparam int AAB_DATA_W = 8;
    localparam int AAB_FILE_W = 7;
    localparam int AAB_FILE_DEPTH = 128;
    localparam logic [6:0] AAB_PORT_FILE_ADDR = 7'h05;
    localparam logic DEST_ACCUMULATOR = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // ------------------------------------------------------------
    // register port map (file space occupies 8'h00 to 8'h7f)
    // ------------------------------------------------------------
    localparam logic [7:0] AAB_FILE_LAST = 8'h7f;
    localparam logic [7:0] AAB_ACC_ADDR = 8'h80;
    localparam logic [7:0] AAB_STATUS_ADDR = 8'h81;
    localparam logic [7:0] AAB_EXEC_ADDR = 8'h82;

    // status field positions
    localparam int AAB_STATUS_CARRY_POS = 0;
    localparam int AAB_STATUS_DIGIT_CARRY_POS = 1;
    localparam int AAB_STATUS_ZERO_POS = 2;

    // reset values
    localparam logic [7:0] AAB_ACC_RESET = 8'h00;
    localparam logic [7:0] AAB_PORT_LATCH_RESET = 8'h00;
    localparam logic AAB_FLAG_RESET = 1'b0;
    localparam logic [7:0] AAB_RDATA_RESET = 8'h00;

endpackage

// ### hw/aab_alu_if.sv
// interface carrying operands and results between core and alu
// assumes both ends sit on the same clock; content is purely combinational
`timescale 1ns/1ps
interface aab_alu_if;
    aab_pkg::aab_op_t op;
    logic [7:0] acc;
    logic [7:0] operand;
    logic [7:0] lit;
    logic [2:0] bit_sel;
    logic [7:0] result;
    logic carry;
    logic digit_carry;
    logic zero;
    logic bit_val;

    modport core (
        output op,
        output acc,
        output operand,
        output lit,
        output bit_sel,
        input result,
        input carry,
        input digit_carry,
        input zero,
        input bit_val
    );

    modport alu (
        input op,
        input acc,
        input operand,
        input lit,
        input bit_sel,
        output result,
        output carry,
        output digit_carry,
        output zero,
        output bit_val
    );
endinterface

// ### hw/aab_alu.sv
// combinational datapath: add, and, bit set/clear, bit test
// assumes the core registers every result it keeps
`timescale 1ns/1ps
module aab_alu (
    aab_alu_if.alu alu
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // 9-bit sum so carry out of bit 7 is bit 8
    function automatic logic [8:0] aab_add(input logic [7:0] a, input logic [7:0] b);
        aab_add = {1'b0, a} + {1'b0, b};
    endfunction

    // carry out of bit 3 from the low nibbles alone
    function automatic logic aab_nibble_carry(input logic [7:0] a, input logic [7:0] b);
        logic [4:0] s;
        s = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        aab_nibble_carry = s[4];
    endfunction

    function automatic logic [7:0] aab_bit_mask(input logic [2:0] b);
        aab_bit_mask = 8'h01 << b;
    endfunction

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    logic [8:0] sum;
    logic [7:0] addend;

    always_comb begin
        addend = (alu.op == aab_pkg::AAB_ADD_LITERAL_TO_ACCUMULATOR) ? alu.lit : alu.operand;
        sum = aab_add(alu.acc, addend);
        alu.carry = 1'b0;
        alu.digit_carry = 1'b0;
        alu.result = 8'h00;
        case (alu.op)
            aab_pkg::AAB_ADD_LITERAL_TO_ACCUMULATOR,
            aab_pkg::AAB_ADD_ACCUMULATOR_AND_FILE: begin
                alu.result = sum[7:0];
                alu.carry = sum[8];
                alu.digit_carry = aab_nibble_carry(alu.acc, addend);
            end
            aab_pkg::AAB_AND_LITERAL_INTO_ACCUMULATOR: begin
                alu.result = alu.acc & alu.lit;
            end
            aab_pkg::AAB_AND_ACCUMULATOR_WITH_FILE: begin
                alu.result = alu.acc & alu.operand;
            end
            aab_pkg::AAB_BIT_CLEAR_FILE: begin
                alu.result = alu.operand & ~aab_bit_mask(alu.bit_sel);
            end
            aab_pkg::AAB_BIT_SET_FILE: begin
                alu.result = alu.operand | aab_bit_mask(alu.bit_sel);
            end
            default: begin
                alu.result = alu.operand;
            end
        endcase
        alu.zero = (alu.result == 8'h00);
        alu.bit_val = alu.operand[alu.bit_sel];
    end

endmodule

// ### verification/aab_core_asserts.sv
// concurrent checks on the accumulator alu and bit-op core
// assumes one clock and a synchronous active-low reset; bound to aab_core
`timescale 1ns/1ps
module aab_core_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire aab_pkg::aab_op_t instr_op,
    input wire logic [7:0] instr_lit,
    input wire logic bus_wr,
    input wire logic instr_retired,
    input wire logic instr_squashed,
    input wire logic skip_pending,
    input wire logic [7:0] acc,
    input wire logic carry_flag,
    input wire logic digit_carry_flag,
    input wire logic zero_flag
);
    // ----
    // helpers
    // ----
    logic run;
    logic sq;
    logic add_go;
    assign run = instr_valid && !skip_pending;
    assign sq = instr_valid && skip_pending;
    assign add_go = run && instr_op == aab_pkg::AAB_ADD_LITERAL_TO_ACCUMULATOR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ----
    // properties
    // ----
    a_retire_pulse: assert property (
        run |=> instr_retired && !instr_squashed) else $error("executed op did not retire");
    // a bus write in the same cycle may legally move acc or flags, so exclude it
    a_squash_drop: assert property (
        sq && !bus_wr |=> instr_squashed && !skip_pending && $stable(acc) && $stable(zero_flag))
        else $error("squashed op changed state");
    a_skip_hold: assert property (
        skip_pending && !instr_valid |=> skip_pending) else $error("skip lost while idle");
    a_skip_cause: assert property (
        $rose(skip_pending) |-> $past(instr_valid)
        && $past(instr_op) == aab_pkg::AAB_TEST_BIT_SKIP_IF_ZERO) else $error("skip without test");
    a_add_sum: assert property (
        add_go |=> acc == 8'($past(acc) + $past(instr_lit))) else $error("add sum wrong");
    a_add_flags: assert property (
        add_go |=> carry_flag == ($past(acc) + $past(instr_lit) > 9'h0ff)
        && digit_carry_flag == (($past(acc) & 8'h0f) + ($past(instr_lit) & 8'h0f) > 8'h0f)
        && zero_flag == (acc == 8'h00)) else $error("add flags wrong");
    a_and_lit: assert property (
        run && !bus_wr && instr_op == aab_pkg::AAB_AND_LITERAL_INTO_ACCUMULATOR
        |=> acc == ($past(acc) & $past(instr_lit)) && zero_flag == (acc == 8'h00)
        && $stable(carry_flag) && $stable(digit_carry_flag)) else $error("and literal wrong");
    a_bit_flags: assert property (
        run && !bus_wr && (instr_op == aab_pkg::AAB_BIT_SET_FILE
        || instr_op == aab_pkg::AAB_BIT_CLEAR_FILE) |=> $stable(acc) && $stable(carry_flag)
        && $stable(digit_carry_flag) && $stable(zero_flag)) else $error("bit op touched flags");
    c_squash: cover property (sq);
    c_add: cover property (add_go);
    c_skip: cover property ($rose(skip_pending));
endmodule
bind aab_core aab_core_asserts u_aab_core_asserts (.clk, .nrst, .instr_valid, .instr_op,
    .instr_lit, .bus_wr, .instr_retired, .instr_squashed, .skip_pending, .acc, .carry_flag,
    .digit_carry_flag, .zero_flag);

// ### verification/tb_accumulator_alu_bit_ops.sv
// directed self-checking bench for aab_core
// assumes the register port map and one-cycle latencies of the core
`timescale 1ns/1ps
module tb_accumulator_alu_bit_ops;
    logic clk, nrst, instr_valid, instr_dest, bus_wr, bus_rd;
    aab_pkg::aab_op_t instr_op;
    logic [7:0] instr_lit, port_pins_in, bus_addr, bus_wdata, acc, port_latch, bus_rdata;
    logic [6:0] instr_file;
    logic [2:0] instr_bit;
    logic instr_retired, instr_squashed, skip_pending, carry_flag, digit_carry_flag, zero_flag;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;

    aab_core u_aab_core (.clk, .nrst, .instr_valid, .instr_op, .instr_lit, .instr_file,
        .instr_dest, .instr_bit, .instr_retired, .instr_squashed, .skip_pending, .acc,
        .carry_flag, .digit_carry_flag, .zero_flag, .port_pins_in, .port_latch, .bus_addr,
        .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----
    // shared tasks
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] fl();
        return {5'h00, zero_flag, digit_carry_flag, carry_flag};
    endfunction

    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
    endtask

    task automatic bus_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        check(bus_rdata, exp);
    endtask

    task automatic exec(input aab_pkg::aab_op_t op, input logic [7:0] k = 8'h00,
        input logic [6:0] f = 7'h00, input logic d = 1'b0, input logic [2:0] b = 3'h0);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_lit <= k;
        instr_file <= f;
        instr_dest <= d;
        instr_bit <= b;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_add_lit();
        check(acc, 8'h00);
        bus_write(aab_pkg::AAB_ACC_ADDR, 8'h0f);
        exec(aab_pkg::AAB_ADD_LITERAL_TO_ACCUMULATOR, 8'h01);
        check(acc, 8'h10);
        check(fl(), 8'h02);
        exec(aab_pkg::AAB_ADD_LITERAL_TO_ACCUMULATOR, 8'hf0);
        check(acc, 8'h00);
        check(fl(), 8'h05);
        exec(aab_pkg::AAB_ADD_LITERAL_TO_ACCUMULATOR, 8'hff);
        check(acc, 8'hff);
        check(fl(), 8'h00);
    endtask

    task automatic t_file_ops();
        bus_write(8'h7f, 8'h35);
        bus_write(aab_pkg::AAB_ACC_ADDR, 8'h11);
        exec(aab_pkg::AAB_ADD_ACCUMULATOR_AND_FILE, 8'h00, 7'h7f, 1'b1);
        check(acc, 8'h11);
        bus_read(8'h7f, 8'h46);
        exec(aab_pkg::AAB_ADD_ACCUMULATOR_AND_FILE, 8'h00, 7'h7f, 1'b0);
        check(acc, 8'h57);
        check(fl(), 8'h00);
        // carry and digit carry preset so only zero may move
        bus_write(aab_pkg::AAB_STATUS_ADDR, 8'h03);
        exec(aab_pkg::AAB_AND_LITERAL_INTO_ACCUMULATOR, 8'ha8);
        check(acc, 8'h00);
        check(fl(), 8'h07);
        bus_write(aab_pkg::AAB_ACC_ADDR, 8'hf0);
        exec(aab_pkg::AAB_AND_ACCUMULATOR_WITH_FILE, 8'h00, 7'h7f, 1'b1);
        check(acc, 8'hf0);
        check(fl(), 8'h03);
        bus_read(8'h7f, 8'h40);
    endtask

    task automatic t_bits();
        logic [7:0] v;
        v = 8'h00;
        bus_write(8'h30, v);
        for (int b = 0; b < 8; b++) begin
            exec(aab_pkg::AAB_BIT_SET_FILE, 8'h00, 7'h30, 1'b0, 3'(b));
            v = v | (8'h01 << b);
            bus_read(8'h30, v);
        end
        for (int b = 0; b < 8; b++) begin
            exec(aab_pkg::AAB_BIT_CLEAR_FILE, 8'h00, 7'h30, 1'b0, 3'(b));
            v = v & ~(8'h01 << b);
            bus_read(8'h30, v);
        end
        check(fl(), 8'h03);
        check(acc, 8'hf0);
    endtask

    task automatic t_skip();
        bus_write(8'h30, 8'h01);
        exec(aab_pkg::AAB_TEST_BIT_SKIP_IF_ZERO, 8'h00, 7'h30, 1'b0, 3'h1);
        check(8'(skip_pending), 8'h01);
        bus_read(aab_pkg::AAB_EXEC_ADDR, 8'h01);
        exec(aab_pkg::AAB_ADD_LITERAL_TO_ACCUMULATOR, 8'h01);
        check(8'(instr_squashed), 8'h01);
        check(acc, 8'hf0);
        check(8'(skip_pending), 8'h00);
        exec(aab_pkg::AAB_TEST_BIT_SKIP_IF_ZERO, 8'h00, 7'h30, 1'b0, 3'h0);
        check(8'(skip_pending), 8'h00);
        exec(aab_pkg::AAB_ADD_LITERAL_TO_ACCUMULATOR, 8'h01);
        check(8'(instr_retired), 8'h01);
        check(acc, 8'hf1);
    endtask

    task automatic t_port();
        // pins disagree with the latch so a latch read would show up
        @(posedge clk);
        port_pins_in <= 8'h0f;
        bus_write({1'b0, aab_pkg::AAB_PORT_FILE_ADDR}, 8'hff);
        check(port_latch, 8'hff);
        bus_write(aab_pkg::AAB_ACC_ADDR, 8'h00);
        exec(aab_pkg::AAB_ADD_ACCUMULATOR_AND_FILE, 8'h00, aab_pkg::AAB_PORT_FILE_ADDR);
        check(acc, 8'h0f);
        exec(aab_pkg::AAB_BIT_CLEAR_FILE, 8'h00, aab_pkg::AAB_PORT_FILE_ADDR, 1'b0, 3'h7);
        check(port_latch, 8'h0f);
        // file add with carry out of both nibbles and a zero result
        bus_write(8'h7f, 8'hf1);
        exec(aab_pkg::AAB_ADD_ACCUMULATOR_AND_FILE, 8'h00, 7'h7f);
        check(acc, 8'h00);
        check(fl(), 8'h07);
        bus_read(aab_pkg::AAB_STATUS_ADDR, 8'h07);
        @(posedge clk);
        #1;
        check(bus_rdata, 8'h00);
        exec(aab_pkg::AAB_NOP);
        check(fl(), 8'h07);
        check(acc, 8'h00);
        bus_read(8'h90, 8'h00);
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // generous ceiling: the whole sequence needs under 150 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        nrst = 1'b0;
        {instr_valid, instr_dest, bus_wr, bus_rd} = 4'h0;
        instr_op = aab_pkg::AAB_NOP;
        {instr_lit, port_pins_in, bus_addr, bus_wdata} = 32'h0;
        instr_file = 7'h00;
        instr_bit = 3'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_add_lit();
        t_file_ops();
        t_bits();
        t_skip();
        t_port();
        print_verdict();
    end
endmodule
